// ==== src/opsq_pkg.sv ====
package opsq_pkg;
	// ------------------------------------------------------------
	// Phase and function encodings
	// ------------------------------------------------------------
	typedef enum logic [6:0] {
		PH_IDLE = 7'h01,
		PH_P3 = 7'h02,
		PH_P4 = 7'h04,
		PH_P5 = 7'h08,
		PH_P6 = 7'h10,
		PH_P1 = 7'h20,
		PH_RUN = 7'h40
	} opsq_phase_e;

	typedef enum logic [7:0] {
		FN_NONE = 8'h00,
		FN_RUN = 8'h01,
		FN_INS1 = 8'h02,
		FN_INS2 = 8'h04,
		FN_DATA = 8'h08,
		FN_STORE = 8'h10,
		FN_DISP = 8'h20,
		FN_INCR = 8'h40,
		FN_WIPE = 8'h80
	} opsq_func_e;

	// ------------------------------------------------------------
	// Panel control switch vector positions
	// ------------------------------------------------------------
	localparam int K_RUN = 0;
	localparam int K_STEP = 1;
	localparam int K_ACTA = 2;
	localparam int K_ACTB = 3;
	localparam int K_INS1 = 4;
	localparam int K_INS2 = 5;
	localparam int K_ENTER = 6;
	localparam int K_CLEAR = 7;
	localparam int K_STO_IP = 8;
	localparam int K_STO_SEL = 9;
	localparam int K_DSP_IP = 10;
	localparam int K_DSP_SEL = 11;
	localparam int K_HOLD = 12;
	localparam int K_INCR = 13;
	localparam int K_CPURST = 14;
	localparam int K_SYSRST = 15;
	localparam int K_INTR = 16;
	localparam int CTL_W = 17;

	// ------------------------------------------------------------
	// Sum bus field positions (panel bit n sits at 31-n)
	// ------------------------------------------------------------
	localparam int S_CC_HI = 31;
	localparam int S_CC_LO = 28;
	localparam int S_FL_HI = 26;
	localparam int S_FL_LO = 23;
	localparam int S_MODE_HI = 21;
	localparam int S_MODE_LO = 20;
	localparam int S_WK_HI = 29;
	localparam int S_WK_LO = 28;
	localparam int S_INH_HI = 26;
	localparam int S_INH_LO = 24;
	localparam int S_RP_HI = 7;
	localparam int S_RP_LO = 4;
	localparam int IP_W = 17;
	localparam logic [31:0] FIRST_STATUS_WORD_KEEP = 32'hFFF00000;
	localparam logic [31:0] SECOND_STATUS_WORD_KEEP = 32'h3FFFFFF0;

	// ------------------------------------------------------------
	// Register map and reset values
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_DISPLAY = 8'h04;
	localparam logic [7:0] OFS_IPTR = 8'h08;
	localparam logic [7:0] OFS_FIRST_STATUS_WORD = 8'h0C;
	localparam logic [7:0] OFS_SECOND_STATUS_WORD = 8'h10;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [31:0] RST_WORD = 32'h00000000;
	localparam logic [16:0] RST_IP = 17'h00000;
endpackage

// ==== src/opsq_sequencer.sv ====
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module opsq_sequencer (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Operator panel, asynchronous.
	input wire logic [opsq_pkg::CTL_W-1:0] panel_ctl,
	input wire logic [31:0] panel_data_sw,
	input wire logic [opsq_pkg::IP_W-1:0] panel_sel_addr,
	// Processor side, same clock.
	input wire logic no_io_connection,
	input wire logic no_address_stop_match,
	input wire logic no_io_function_strobe,
	input wire logic io_service_call_set,
	input wire logic end_of_execution,
	output logic branch_phase10,
	output logic [31:0] exec_instr,
	output logic internal_io_service_call,
	output logic halt,
	output logic [6:0] panel_phase,
	output logic [31:0] display_word,
	// Reset outputs.
	output logic io_system_reset,
	output logic memory_fault_reset,
	output logic memory_control_init,
	output logic wipe_memory_request,
	// Core memory.
	output logic mem_req,
	output logic mem_we,
	output logic [opsq_pkg::IP_W-1:0] mem_addr,
	output logic [31:0] mem_wdata,
	input wire logic [31:0] mem_rdata,
	input wire logic mem_data_release,
	output logic data_request_wait,
	// AXI4-Lite slave.
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import opsq_pkg::*;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [CTL_W-1:0] ctl_m_q, k;
	logic [31:0] dsw_m_q, dsw;
	logic [IP_W-1:0] sel_m_q, sel;
	opsq_phase_e ph_q, ph_d;
	opsq_func_e fn_q, fn_d;
	logic [31:0] disp_q, acc_q, b_q, first_status_word_q, second_status_word_q, sum;
	logic [IP_W-1:0] ip_q;
	logic halt_q, drq_q, we_q, internal_io_service_call_q, br_q, run_q;
	logic rio_q, mfr_q, mr_q, wipe, go, idle, mem_go;
	logic ip_wr;

	// ------------------------------------------------------------
	// Panel synchronisers
	// ------------------------------------------------------------
	// Switches bounce and change at any time, so each passes two flops.
	always_ff @(posedge aclk) begin
		ctl_m_q <= panel_ctl;
		k <= ctl_m_q;
		dsw_m_q <= panel_data_sw;
		dsw <= dsw_m_q;
		sel_m_q <= panel_sel_addr;
		sel <= sel_m_q;
	end

	// ------------------------------------------------------------
	// Launch decode
	// ------------------------------------------------------------
	// wipe request decode.
	assign wipe = k[K_CPURST] & k[K_SYSRST] & ~k[K_RUN] & ~k[K_STEP];
	assign idle = (ph_q == PH_IDLE);
	assign go = idle & no_io_connection & no_address_stop_match &
		(wipe | (k[K_INTR] & k[K_RUN]) | (~halt_q & k[K_ACTA] & k[K_ACTB]));

	// Priority among switches when several act together.
	always_comb begin
		if (wipe)
			fn_d = FN_WIPE;
		else if (k[K_RUN] | k[K_STEP])
			fn_d = FN_RUN;
		else if (k[K_INS1])
			fn_d = FN_INS1;
		else if (k[K_INS2])
			fn_d = FN_INS2;
		else if (k[K_ENTER] | k[K_CLEAR])
			fn_d = FN_DATA;
		else if (k[K_STO_IP] | k[K_STO_SEL])
			fn_d = FN_STORE;
		else if (k[K_DSP_IP] | k[K_DSP_SEL])
			fn_d = FN_DISP;
		else if (k[K_INCR])
			fn_d = FN_INCR;
		else
			fn_d = FN_NONE;
	end

	// A memory access opens in phase four for these functions.
	assign mem_go = (ph_q == PH_P4) &
		(fn_q == FN_STORE || fn_q == FN_DISP || fn_q == FN_INCR || fn_q == FN_WIPE);

	// ------------------------------------------------------------
	// Sum bus
	// ------------------------------------------------------------
	// display word routed to sum except in phase four of an insert and in phase five of any function but store.
	always_comb begin
		sum = disp_q;
		if (ph_q == PH_P4 && (fn_q == FN_INS1 || fn_q == FN_INS2))
			sum = acc_q | ((fn_q == FN_INS1) ? {15'h0000, ip_q} : 32'h00000000);
		else if (ph_q == PH_P5 && fn_q != FN_STORE)
			sum = acc_q;
	end

	// ------------------------------------------------------------
	// Phase sequencer
	// ------------------------------------------------------------
	// fixed order, one phase per clock outside idle and waits.
	always_comb begin
		ph_d = ph_q;
		unique case (ph_q)
			PH_IDLE: if (go && fn_d != FN_NONE) ph_d = PH_P3;
			PH_P3: ph_d = (fn_q == FN_RUN) ? PH_RUN : PH_P4;
			PH_P4: ph_d = PH_P5;
			// wait holds phase five until release.
			PH_P5: if (!drq_q || mem_data_release) begin
				// wipe repeats phase five while held.
				if (!(fn_q == FN_WIPE && wipe))
					ph_d = PH_P6;
			end
			PH_P6: ph_d = PH_P1;
			PH_P1: ph_d = PH_IDLE;
			PH_RUN: if (end_of_execution && (k[K_STEP] || !k[K_RUN]))
				ph_d = PH_P1;
			default: ph_d = PH_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ph_q <= PH_IDLE;
			fn_q <= FN_NONE;
		end else begin
			ph_q <= ph_d;
			if (idle)
				fn_q <= fn_d;
		end
	end

	// Halt set leaving a sequence, cleared in idle once switches rest.
	always_ff @(posedge aclk) begin
		if (!aresetn)
			halt_q <= 1'b1;
		else if (ph_q == PH_P6 || (ph_q == PH_RUN && ph_d == PH_P1))
			halt_q <= 1'b1;
		else if (idle && !(k[K_ACTA] & k[K_ACTB]))
			halt_q <= 1'b0;
	end

	// branch to execution phase 10 after phase three.
	always_ff @(posedge aclk) begin
		if (!aresetn)
			br_q <= 1'b0;
		else
			br_q <= (ph_q == PH_P3) && (fn_q == FN_RUN);
	end

	// ------------------------------------------------------------
	// Reset and wipe outputs
	// ------------------------------------------------------------
	// idle reset outputs.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rio_q <= 1'b0;
			mfr_q <= 1'b0;
			mr_q <= 1'b0;
		end else begin
			rio_q <= idle & k[K_SYSRST] & ~wipe;
			mfr_q <= idle & (k[K_SYSRST] | k[K_CPURST]) & ~wipe;
			mr_q <= idle & k[K_SYSRST] & ~k[K_CPURST];
		end
	end

	// ------------------------------------------------------------
	// Accumulator and B register
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc_q <= RST_WORD;
			b_q <= RST_WORD;
		end else begin
			if (ph_q == PH_P3) begin
				// old status bits saved, others zero.
				if (fn_q == FN_INS1)
					acc_q <= first_status_word_q & FIRST_STATUS_WORD_KEEP;
				else if (fn_q == FN_INS2)
					acc_q <= second_status_word_q & SECOND_STATUS_WORD_KEEP;
				else
					acc_q <= RST_WORD;
				// instruction saved in B via sum; store, display and increment save the pointer.
				if (fn_q == FN_STORE || fn_q == FN_DISP || fn_q == FN_INCR)
					b_q <= {15'h0000, ip_q};
				else
					b_q <= sum;
			end else if (ph_q == PH_P4 && fn_q != FN_WIPE && fn_q != FN_STORE) begin
				// data switches into accumulator, down switches clear.
				acc_q <= (fn_q == FN_DATA && k[K_CLEAR]) ? RST_WORD : dsw;
			end
		end
	end

	// ------------------------------------------------------------
	// Display data register
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn)
			disp_q <= RST_WORD;
		else if (ph_q == PH_P4 && fn_q != FN_STORE && fn_q != FN_DISP && fn_q != FN_INCR)
			disp_q <= (fn_q == FN_WIPE || fn_q == FN_DATA) ? RST_WORD : sum;
		else if (ph_q == PH_P5 && fn_q == FN_DATA)
			// enter loads switches, clear loads zeros.
			disp_q <= sum;
		else if (ph_q == PH_P5 && drq_q && mem_data_release && !we_q)
			disp_q <= mem_rdata;
		else if (ph_q == PH_P6 && (fn_q == FN_INS1 || fn_q == FN_INS2 || fn_q == FN_WIPE))
			disp_q <= b_q;
	end

	// ------------------------------------------------------------
	// Status words
	// ------------------------------------------------------------
	// insertion only sets bits; only reset clears them.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			first_status_word_q <= RST_WORD;
			second_status_word_q <= RST_WORD;
		end else if (ph_q == PH_P5) begin
			// code, flags, mode from the sum.
			if (fn_q == FN_INS1) begin
				first_status_word_q[S_CC_HI:S_CC_LO] <= first_status_word_q[S_CC_HI:S_CC_LO] | sum[S_CC_HI:S_CC_LO];
				first_status_word_q[S_FL_HI:S_FL_LO] <= first_status_word_q[S_FL_HI:S_FL_LO] | sum[S_FL_HI:S_FL_LO];
				first_status_word_q[S_MODE_HI:S_MODE_LO] <=
					first_status_word_q[S_MODE_HI:S_MODE_LO] | sum[S_MODE_HI:S_MODE_LO];
			end
			if (fn_q == FN_INS2) begin
				second_status_word_q[S_WK_HI:S_WK_LO] <= second_status_word_q[S_WK_HI:S_WK_LO] | sum[S_WK_HI:S_WK_LO];
				second_status_word_q[S_INH_HI:S_INH_LO] <= second_status_word_q[S_INH_HI:S_INH_LO] | sum[S_INH_HI:S_INH_LO];
				second_status_word_q[S_RP_HI:S_RP_LO] <= second_status_word_q[S_RP_HI:S_RP_LO] | sum[S_RP_HI:S_RP_LO];
			end
		end
	end

	// ------------------------------------------------------------
	// Instruction pointer
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn)
			ip_q <= RST_IP;
		else if (ip_wr)
			ip_q <= s_axi_wdata[IP_W-1:0];
		else if (ph_q == PH_P4 && (k[K_STO_SEL] || k[K_DSP_SEL]) &&
			(fn_q == FN_STORE || fn_q == FN_DISP))
			ip_q <= sel;
		else if (ph_q == PH_P4 && fn_q == FN_INCR)
			ip_q <= ip_q + 17'h00001;
		else if (ph_q == PH_P5 && fn_q == FN_WIPE && drq_q && mem_data_release)
			ip_q <= ip_q + 17'h00001;
		else if (ph_q == PH_P6 && (fn_q == FN_STORE || fn_q == FN_DISP))
			ip_q <= b_q[IP_W-1:0];
		else if (ph_q == PH_RUN && end_of_execution && !k[K_HOLD])
			// advance at end of execution; hold keeps it.
			ip_q <= ip_q + 17'h00001;
	end

	// ------------------------------------------------------------
	// Memory request and wait
	// ------------------------------------------------------------
	// wait flag raised with each access.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			drq_q <= 1'b0;
			we_q <= 1'b0;
		end else if (mem_go) begin
			drq_q <= 1'b1;
			we_q <= (fn_q == FN_STORE) || (fn_q == FN_WIPE);
		end else if (drq_q && mem_data_release) begin
			// another zero write while the buttons stay down.
			drq_q <= (fn_q == FN_WIPE) && wipe;
		end
	end

	// service call cleared without a function strobe.
	always_ff @(posedge aclk) begin
		if (!aresetn)
			internal_io_service_call_q <= 1'b0;
		else if (io_service_call_set)
			internal_io_service_call_q <= 1'b1;
		else if (ph_q == PH_P3 && no_io_function_strobe)
			internal_io_service_call_q <= 1'b0;
	end

	// ------------------------------------------------------------
	// Output assignments
	// ------------------------------------------------------------
	assign run_q = (ph_q == PH_RUN);
	assign branch_phase10 = br_q;
	// display word is the instruction executed next.
	assign exec_instr = disp_q;
	assign internal_io_service_call = internal_io_service_call_q;
	assign halt = halt_q;
	assign panel_phase = ph_q;
	assign display_word = disp_q;
	assign io_system_reset = rio_q;
	assign memory_fault_reset = mfr_q;
	assign memory_control_init = mr_q;
	assign wipe_memory_request = (fn_q == FN_WIPE) && !idle;
	assign data_request_wait = drq_q;
	assign mem_req = drq_q;
	assign mem_we = we_q;
	assign mem_addr = ip_q;
	// Wipe writes the zero held in display; store writes display.
	assign mem_wdata = disp_q;

	// ------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------
	// Address and data are taken together, so no skid buffer is needed.
	logic wr_take, rd_take;
	assign wr_take = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
	assign rd_take = s_axi_arvalid & ~s_axi_rvalid;
	assign s_axi_awready = wr_take;
	assign s_axi_wready = wr_take;
	assign s_axi_arready = rd_take;
	// Pointer writes land only in idle to keep sequences coherent.
	assign ip_wr = wr_take && s_axi_awaddr == OFS_IPTR && idle && s_axi_wstrb != 4'h0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (wr_take) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (s_axi_awaddr == OFS_IPTR) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= RST_WORD;
			s_axi_rresp <= RESP_OKAY;
		end else if (rd_take) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			unique case (s_axi_araddr)
				OFS_STATUS: s_axi_rdata <= {19'h00000, drq_q, halt_q, run_q, ph_q, 3'h0};
				OFS_DISPLAY: s_axi_rdata <= disp_q;
				OFS_IPTR: s_axi_rdata <= {15'h0000, ip_q};
				OFS_FIRST_STATUS_WORD: s_axi_rdata <= first_status_word_q;
				OFS_SECOND_STATUS_WORD: s_axi_rdata <= second_status_word_q;
				default: begin
					s_axi_rdata <= RST_WORD;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_run_launch;
		idle && go && fn_d == FN_RUN;
	endsequence
	sequence s_branch;
		ph_q == PH_P3 ##1 ph_q == PH_RUN && br_q;
	endsequence
	sequence s_finish;
		ph_q == PH_P6 ##1 ph_q == PH_P1 && halt_q ##1 ph_q == PH_IDLE;
	endsequence

	reset_outputs_a: assert property (idle && k[K_SYSRST] && !wipe |=> rio_q && mfr_q)
		else $error("reset outputs missing in idle");
	idle_stay_a: assert property (idle && !go |=> ph_q == PH_IDLE)
		else $error("left idle without a trigger");
	run_branch_a: assert property (s_run_launch |=> s_branch)
		else $error("run launch did not branch to phase 10");
	psw_only_set_a: assert property ((first_status_word_q & $past(first_status_word_q)) == $past(first_status_word_q))
		else $error("status word bit cleared by insertion");
	insert_acc_a: assert property (ph_q == PH_P3 && fn_q == FN_INS2
		|=> acc_q == ($past(second_status_word_q) & SECOND_STATUS_WORD_KEEP))
		else $error("accumulator not loaded with old status");
	internal_io_service_call_clear_a: assert property (ph_q == PH_P3 && no_io_function_strobe
		&& !io_service_call_set |=> !internal_io_service_call_q)
		else $error("service call survived phase three");
	insert_end_a: assert property (ph_q == PH_P6 && fn_q == FN_INS1 |-> s_finish)
		else $error("insert did not halt and return to idle");
	wait_hold_a: assert property (ph_q == PH_P5 && drq_q && !mem_data_release
		|=> ph_q == PH_P5 && drq_q)
		else $error("phase moved before data release");
	exec_step_a: assert property (run_q && end_of_execution && !k[K_HOLD]
		|=> ip_q == $past(ip_q) + 17'h00001)
		else $error("pointer not advanced after execution");
	hold_keep_a: assert property (run_q && end_of_execution && k[K_HOLD]
		|=> ip_q == $past(ip_q))
		else $error("pointer moved under address hold");
	one_clock_a: assert property (ph_q == PH_P4 |=> ph_q == PH_P5)
		else $error("phase four lasted more than one clock");
endmodule // opsq_sequencer
`default_nettype wire

// ==== tb/opsq_mem_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// Core memory stand-in; DLY sets how slowly each access is released.
module opsq_mem_model #(
	parameter int DLY = 3
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Memory port.
	input wire logic req,
	input wire logic we,
	input wire logic [16:0] addr,
	input wire logic [31:0] wdata,
	output logic [31:0] rdata,
	output logic rel_q
);
	logic [31:0] mem [0:31];
	int cnt_q;
	// release after delay
	// The quiet cycle after a release stops a double release; in it and while no request waits the read
	// data flips every cycle so that a stale word never looks valid.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= 0;
			rel_q <= 1'b0;
			rdata <= 32'h00000000;
			for (int i = 0; i < 32; i++) begin
				mem[i] <= 32'h00C0DE00 | 32'(i);
			end
		end else begin
			rel_q <= 1'b0;
			if (req && !rel_q && cnt_q >= DLY) begin
				rel_q <= 1'b1;
				cnt_q <= 0;
				if (we) begin
					mem[addr[4:0]] <= wdata;
				end else begin
					rdata <= mem[addr[4:0]];
				end
			end else if (req && !rel_q) begin
				cnt_q <= cnt_q + 1;
			end else begin
				rdata <= ~rdata;
			end
		end
	end
endmodule // opsq_mem_model
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import opsq_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [CTL_W-1:0] panel_ctl = '0;
	logic [31:0] panel_data_sw = '0;
	logic [IP_W-1:0] panel_sel_addr = '0;
	logic no_io_connection = 1'b1, no_address_stop_match = 1'b1, no_io_function_strobe = 1'b1;
	logic io_service_call_set = 1'b0, end_of_execution = 1'b0;
	logic branch_phase10, internal_io_service_call, halt, io_system_reset;
	logic memory_fault_reset, memory_control_init, wipe_memory_request;
	logic mem_req, mem_we, mem_data_release, data_request_wait;
	logic [6:0] panel_phase;
	logic [31:0] exec_instr, display_word, mem_wdata, mem_rdata, s_axi_rdata, rd;
	logic [31:0] s_axi_wdata = '0;
	logic [IP_W-1:0] mem_addr;
	logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int failures = 0;
	int num_checks = 0;

	opsq_sequencer opsq_sequencer_inst (
		.aclk, .aresetn, .panel_ctl, .panel_data_sw, .panel_sel_addr,
		.no_io_connection, .no_address_stop_match, .no_io_function_strobe,
		.io_service_call_set, .end_of_execution, .branch_phase10, .exec_instr,
		.internal_io_service_call, .halt, .panel_phase, .display_word,
		.io_system_reset, .memory_fault_reset, .memory_control_init, .wipe_memory_request,
		.mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_data_release,
		.data_request_wait, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready
	);
	opsq_mem_model #(.DLY(3)) opsq_mem_model_inst (
		.aclk(aclk), .aresetn(aresetn), .req(mem_req), .we(mem_we), .addr(mem_addr),
		.wdata(mem_wdata), .rdata(mem_rdata), .rel_q(mem_data_release)
	);

	// Free-running 100 MHz clock.
	always #5 aclk = ~aclk;

	// --------------------------------
	// Shared tasks
	// --------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// Works one panel function with both action lines, then releases the switches.
	task automatic op(input int k);
		int n;
		@(posedge aclk);
		panel_ctl[k] <= 1'b1;
		panel_ctl[K_ACTA] <= 1'b1;
		panel_ctl[K_ACTB] <= 1'b1;
		n = 0;
		while (panel_phase !== PH_P1 && n < 200) begin
			@(posedge aclk);
			n++;
		end
		if (n >= 200) failures++;
		@(posedge aclk);
		chk(32'(panel_phase), 32'(PH_IDLE));
		chk(32'(halt), 32'h00000001);
		panel_ctl <= '0;
		cyc(6);
		chk(32'(halt), 32'h00000000);
	endtask

	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && n < 50);
		s_axi_bready <= 1'b0;
		chk(32'(s_axi_bresp), 32'(er));
	endtask

	task automatic axr(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && n < 50);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		chk(32'(s_axi_rresp), 32'(er));
	endtask

	// --------------------------------
	// Scenarios
	// --------------------------------
	task automatic t_sysrst;
		@(posedge aclk);
		panel_ctl[K_SYSRST] <= 1'b1;
		cyc(5);
		chk(32'(io_system_reset), 32'h00000001);
		chk(32'(memory_fault_reset), 32'h00000001);
		chk(32'(memory_control_init), 32'h00000001);
		panel_ctl <= '0;
		cyc(6);
		chk(32'(io_system_reset), 32'h00000000);
	endtask

	task automatic t_store;
		@(posedge aclk);
		panel_data_sw <= 32'hA5A50F0F;
		panel_sel_addr <= 17'h00005;
		op(K_ENTER);
		chk(display_word, 32'hA5A50F0F);
		chk(exec_instr, 32'hA5A50F0F);
		op(K_STO_SEL);
		chk(opsq_mem_model_inst.mem[5], 32'hA5A50F0F);
		op(K_CLEAR);
		chk(display_word, 32'h00000000);
		op(K_DSP_SEL);
		chk(display_word, 32'hA5A50F0F);
	endtask

	task automatic t_ptr;
		axw(OFS_IPTR, 32'h00000007, RESP_OKAY);
		op(K_DSP_IP);
		chk(display_word, 32'h00C0DE07);
		op(K_INCR);
		chk(display_word, 32'h00C0DE08);
		axr(OFS_IPTR, RESP_OKAY, rd);
		chk(rd, 32'h00000008);
		panel_data_sw <= 32'h5A5AF0F0;
		op(K_ENTER);
		op(K_STO_IP);
		chk(opsq_mem_model_inst.mem[8], 32'h5A5AF0F0);
		axw(8'h40, 32'h00000001, RESP_SLVERR);
		axr(8'h40, RESP_SLVERR, rd);
		chk(rd, 32'h00000000);
	endtask

	task automatic t_insert;
		@(posedge aclk);
		io_service_call_set <= 1'b1;
		@(posedge aclk);
		io_service_call_set <= 1'b0;
		panel_data_sw <= 32'hF0000000;
		cyc(2);
		chk(32'(internal_io_service_call), 32'h00000001);
		op(K_INS1);
		chk(32'(internal_io_service_call), 32'h00000000);
		chk(display_word, 32'h5A5AF0F0);
		axr(OFS_FIRST_STATUS_WORD, RESP_OKAY, rd);
		chk(32'(rd[S_CC_HI:S_CC_LO]), 32'h0000000F);
		panel_data_sw <= 32'h00000000;
		op(K_INS1);
		axr(OFS_FIRST_STATUS_WORD, RESP_OKAY, rd);
		chk(32'(rd[S_CC_HI:S_CC_LO]), 32'h0000000F);
		panel_data_sw <= 32'h000000F0;
		op(K_INS2);
		axr(OFS_SECOND_STATUS_WORD, RESP_OKAY, rd);
		chk(32'(rd[S_RP_HI:S_RP_LO]), 32'h0000000F);
	endtask

	// Run from idle under address hold, then let the run end with the pointer moving.
	task automatic t_run;
		int n;
		panel_data_sw <= 32'h12345678;
		op(K_ENTER);
		axw(OFS_IPTR, 32'h00000010, RESP_OKAY);
		@(posedge aclk);
		panel_ctl[K_RUN] <= 1'b1;
		panel_ctl[K_HOLD] <= 1'b1;
		panel_ctl[K_ACTA] <= 1'b1;
		panel_ctl[K_ACTB] <= 1'b1;
		n = 0;
		while (panel_phase !== PH_RUN && n < 50) begin
			@(posedge aclk);
			n++;
		end
		if (n >= 50) failures++;
		chk(32'(branch_phase10), 32'h00000001);
		chk(exec_instr, 32'h12345678);
		end_of_execution <= 1'b1;
		@(posedge aclk);
		end_of_execution <= 1'b0;
		axr(OFS_IPTR, RESP_OKAY, rd);
		chk(rd, 32'h00000010);
		chk(32'(panel_phase), 32'(PH_RUN));
		panel_ctl[K_HOLD] <= 1'b0;
		panel_ctl[K_RUN] <= 1'b0;
		cyc(3);
		end_of_execution <= 1'b1;
		@(posedge aclk);
		end_of_execution <= 1'b0;
		cyc(4);
		chk(32'(panel_phase), 32'(PH_IDLE));
		chk(32'(halt), 32'h00000001);
		axr(OFS_IPTR, RESP_OKAY, rd);
		chk(rd, 32'h00000011);
		panel_ctl <= '0;
		cyc(6);
	endtask

	// Both reset buttons held for several writes; the saved display word comes back.
	task automatic t_wipe;
		int n;
		axw(OFS_IPTR, 32'h00000000, RESP_OKAY);
		@(posedge aclk);
		panel_ctl[K_CPURST] <= 1'b1;
		panel_ctl[K_SYSRST] <= 1'b1;
		cyc(30);
		chk(32'(wipe_memory_request), 32'h00000001);
		chk(32'(io_system_reset), 32'h00000000);
		panel_ctl <= '0;
		n = 0;
		while (panel_phase !== PH_IDLE && n < 50) begin
			@(posedge aclk);
			n++;
		end
		if (n >= 50) failures++;
		chk(32'(wipe_memory_request), 32'h00000000);
		chk(opsq_mem_model_inst.mem[0], 32'h00000000);
		chk(opsq_mem_model_inst.mem[2], 32'h00000000);
		chk(opsq_mem_model_inst.mem[31], 32'h00C0DE1F);
		chk(display_word, 32'h12345678);
		cyc(6);
	endtask

	// Main sequence: ten cycles of reset, then the scenarios in turn.
	initial begin
		cyc(10);
		aresetn <= 1'b1;
		cyc(3);
		chk(32'(panel_phase), 32'(PH_IDLE));
		t_sysrst();
		t_store();
		t_ptr();
		t_insert();
		t_run();
		t_wipe();
		give_verdict();
	end

	// The scenarios take a few hundred cycles; this cuts a hang well beyond that.
	initial begin
		#200us;
		failures++;
		give_verdict();
	end
endmodule // testbench
`default_nettype wire
